// [include/jltx_pkg.sv]
// shared constants and types for the serial link transmitter
package jltx_pkg;
    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_MODE = 4'h4;
    localparam logic [3:0] ADDR_PREEMPH = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;

    // control register bit positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_SCRAMBLE_BIT = 1;
    localparam int CTRL_SUBCLASS1_BIT = 2;
    // mode register field positions
    localparam int MODE_SEL_LSB = 0;
    localparam int MODE_K_LSB = 8;

    // ****************************************************************
    // values after reset
    // ****************************************************************
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [3:0] MODE_SEL_RESET = 4'h0;
    localparam logic [4:0] K_MINUS1_RESET = 5'h0F;
    localparam logic [3:0] PREEMPH_RESET = 4'h0;

    // ****************************************************************
    // control characters and counts
    // ****************************************************************
    localparam logic [7:0] K28_0 = 8'h1C;
    localparam logic [7:0] K28_3 = 8'h7C;
    localparam logic [7:0] K28_4 = 8'h9C;
    localparam logic [7:0] K28_5 = 8'hBC;
    localparam logic [7:0] K28_7 = 8'hFC;
    localparam logic [7:0] SCR_MARK_OCTET = 8'hFC;
    localparam logic [1:0] ILAS_LAST_MF = 2'h3;
    localparam logic [3:0] SYNC_REASSERT_CYCLES = 4'h8;

    // transport mode codes
    localparam logic [3:0] MODE_RAW_F1 = 4'h0;
    localparam logic [3:0] MODE_RAW_F2 = 4'h1;
    localparam logic [3:0] MODE_DDC_F2 = 4'h2;
    localparam logic [3:0] MODE_DDC_F4 = 4'h3;

    typedef enum logic [2:0] {ST_OFF, ST_CGS, ST_WAIT, ST_ILAS, ST_DATA} jltx_state_type;

    typedef struct packed {
        logic isK;
        logic [7:0] value;
    } jltx_octet_type;

    typedef struct packed {
        logic [15:0] i;
        logic [15:0] q;
    } jltx_iq_type;
endpackage

// [src/jltx_top.sv]
// serial link transmitter: transport packing, link bring-up, scrambling, 8b/10b
//
// Behaviour
// - pack raw or down-converted samples into octets, frames and multiframes on one lane.
// - mode select plus frames-per-multiframe K choose the sample-to-lane mapping.
// - scramble octets when scramble_enable is set.
// - the alignment sequence is never scrambled.
// - while sync request is active, send continuous K28.5; in alignment and data the request must first last eight cycles.
// - after sync release, start alignment sequence at our next multiframe edge.
// - alignment sequence lasts exactly four multiframes.
// - second alignment multiframe carries the link configuration.
// - every octet is 8b/10b encoded with running disparity.
// - unscrambled: repeated frame-final octet becomes K28.7, K28.3 at multiframe end.
// - scrambled: frame-final 0xFC becomes K28.7, multiframe-final 0xFC K28.3.
// - serializer pre-emphasis level is programmable, larger means stronger.
// - link_enable low holds link in reset and powers serializer down.
// - writing link_enable one starts the link with current parameters.
// - system reference capture resets the multiframe counters.
// - subclass 0 runs multiframe counters freely; sync still starts bring-up.
//
// The strobed register port and the register offsets were decided locally.
module jltx_top
(
    input wire logic clock,
    input wire logic reset,
    input wire logic clockEnable,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regReadData,
    input wire logic [15:0] adcSample,
    input wire jltx_pkg::jltx_iq_type ddcSample,
    output logic sampleTaken,
    input wire logic syncPinN,
    input wire logic sysrefPin,
    output logic [9:0] lineChar,
    output logic lineValid,
    output logic serPowerDown,
    output logic [3:0] serPreEmphasis
);
    // ****************************************************************
    // lookup and coding functions
    // ****************************************************************
    // 5b/6b codes for negative disparity, bit a in the msb
    function automatic logic [5:0] tab6(input logic [4:0] x);
        unique case (x)
            5'h00: tab6 = 6'h27;
            5'h01: tab6 = 6'h1D;
            5'h02: tab6 = 6'h2D;
            5'h03: tab6 = 6'h31;
            5'h04: tab6 = 6'h35;
            5'h05: tab6 = 6'h29;
            5'h06: tab6 = 6'h19;
            5'h07: tab6 = 6'h38;
            5'h08: tab6 = 6'h39;
            5'h09: tab6 = 6'h25;
            5'h0A: tab6 = 6'h15;
            5'h0B: tab6 = 6'h34;
            5'h0C: tab6 = 6'h0D;
            5'h0D: tab6 = 6'h2C;
            5'h0E: tab6 = 6'h1C;
            5'h0F: tab6 = 6'h17;
            5'h10: tab6 = 6'h1B;
            5'h11: tab6 = 6'h23;
            5'h12: tab6 = 6'h13;
            5'h13: tab6 = 6'h32;
            5'h14: tab6 = 6'h0B;
            5'h15: tab6 = 6'h2A;
            5'h16: tab6 = 6'h1A;
            5'h17: tab6 = 6'h3A;
            5'h18: tab6 = 6'h33;
            5'h19: tab6 = 6'h26;
            5'h1A: tab6 = 6'h16;
            5'h1B: tab6 = 6'h36;
            5'h1C: tab6 = 6'h0E;
            5'h1D: tab6 = 6'h2E;
            5'h1E: tab6 = 6'h1E;
            5'h1F: tab6 = 6'h2B;
        endcase
    endfunction

    // 3b/4b codes for negative disparity, bit f in the msb
    function automatic logic [3:0] tab4(input logic [2:0] y);
        unique case (y)
            3'h0: tab4 = 4'hB;
            3'h1: tab4 = 4'h9;
            3'h2: tab4 = 4'h5;
            3'h3: tab4 = 4'hC;
            3'h4: tab4 = 4'hD;
            3'h5: tab4 = 4'hA;
            3'h6: tab4 = 4'h6;
            3'h7: tab4 = 4'hE;
        endcase
    endfunction

    // returns {new disparity, code}; control codes built at rd- then mirrored
    function automatic logic [10:0] encode(input jltx_pkg::jltx_octet_type o, input logic rdIn);
        logic [5:0] c6;
        logic [3:0] c4;
        logic rd;
        logic [9:0] code;
        rd = o.isK ? 1'b0 : rdIn;
        c6 = o.isK ? 6'h0F : tab6(o.value[4:0]);
        if (rd && (($countones(c6) != 3) || (c6 == 6'h38)))
            c6 = ~c6;
        rd = rd ^ ($countones(c6) != 3);
        c4 = tab4(o.value[7:5]);
        if ((o.value[7:5] == 3'h7) && (o.isK || (!rd && (c6[1:0] == 2'b11)) ||
            (rd && (c6[1:0] == 2'b00))))
            c4 = 4'h7;
        if (rd && (($countones(c4) != 2) || (o.value[7:5] == 3'h3)))
            c4 = ~c4;
        code = {c6, c4};
        if (o.isK && rdIn)
            code = ~code;
        encode = {rdIn ^ ($countones(code) != 5), code};
    endfunction

    // self-synchronous scrambler, msb first; returns {state, octet}
    function automatic logic [22:0] scramble(input logic [7:0] d, input logic [14:0] s);
        logic [14:0] st;
        logic [7:0] q;
        st = s;
        q = 8'h00;
        for (int i = 7; i >= 0; i--)
        begin
            q[i] = d[i] ^ st[13] ^ st[14];
            st = {st[13:0], q[i]};
        end
        scramble = {st, q};
    endfunction

    // octets per frame minus one, per transport mode
    function automatic logic [1:0] frameLast(input logic [3:0] mode);
        unique case (mode)
            jltx_pkg::MODE_RAW_F1: frameLast = 2'h0;
            jltx_pkg::MODE_DDC_F4: frameLast = 2'h3;
            default: frameLast = 2'h1;
        endcase
    endfunction

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [2:0] ctrl_q;
    logic [3:0] modeSel_q;
    logic [4:0] kMinus1_q;
    logic [3:0] preEmph_q;
    logic [31:0] regReadData_q;
    jltx_pkg::jltx_state_type state_q;
    logic [1:0] ilasMf_q;
    logic syncLevel_q;

    logic linkOn;
    logic scrOn;
    assign linkOn = ctrl_q[jltx_pkg::CTRL_ENABLE_BIT];
    assign scrOn = ctrl_q[jltx_pkg::CTRL_SCRAMBLE_BIT];

    // software writes; parameters are only meant to change while disabled
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            ctrl_q <= jltx_pkg::CTRL_RESET;
            modeSel_q <= jltx_pkg::MODE_SEL_RESET;
            kMinus1_q <= jltx_pkg::K_MINUS1_RESET;
            preEmph_q <= jltx_pkg::PREEMPH_RESET;
        end
        else if (clockEnable && regWrite)
        begin
            unique case (regAddr)
                jltx_pkg::ADDR_CTRL: ctrl_q <= regWriteData[2:0];
                jltx_pkg::ADDR_MODE:
                begin
                    modeSel_q <= regWriteData[jltx_pkg::MODE_SEL_LSB +: 4];
                    kMinus1_q <= regWriteData[jltx_pkg::MODE_K_LSB +: 5];
                end
                jltx_pkg::ADDR_PREEMPH: preEmph_q <= regWriteData[3:0];
                default: ;
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            regReadData_q <= 32'h0000_0000;
        else if (clockEnable)
        begin
            regReadData_q <= 32'h0000_0000;
            if (regRead)
            begin
                unique case (regAddr)
                    jltx_pkg::ADDR_CTRL: regReadData_q <= {29'h0000_0000, ctrl_q};
                    jltx_pkg::ADDR_MODE: regReadData_q <= {19'h0_0000, kMinus1_q, 4'h0, modeSel_q};
                    jltx_pkg::ADDR_PREEMPH: regReadData_q <= {28'h000_0000, preEmph_q};
                    jltx_pkg::ADDR_STATUS:
                        regReadData_q <= {26'h000_0000, ilasMf_q, syncLevel_q, 3'(state_q)};
                    default: ;
                endcase
            end
        end
    end

    assign regReadData = regReadData_q;
    assign serPreEmphasis = preEmph_q;
    assign serPowerDown = ~linkOn;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [2:0] syncPipe_q;
    logic [2:0] sysrefPipe_q;
    logic sysrefLevel_q;

    // three stages; a change counts once stages two and three agree
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            syncPipe_q <= 3'h0;
            sysrefPipe_q <= 3'h0;
            syncLevel_q <= 1'b0;
            sysrefLevel_q <= 1'b0;
        end
        else if (clockEnable)
        begin
            syncPipe_q <= {syncPipe_q[1:0], syncPinN};
            sysrefPipe_q <= {sysrefPipe_q[1:0], sysrefPin};
            if (syncPipe_q[1] == syncPipe_q[2])
                syncLevel_q <= syncPipe_q[2];
            if (sysrefPipe_q[1] == sysrefPipe_q[2])
                sysrefLevel_q <= sysrefPipe_q[2];
        end
    end

    logic sysrefEdge;
    assign sysrefEdge = sysrefPipe_q[1] && sysrefPipe_q[2] && !sysrefLevel_q;

    // ****************************************************************
    // frame and multiframe counters
    // ****************************************************************
    logic [1:0] octetIdx_q;
    logic [4:0] frameIdx_q;
    logic [6:0] mfOctet_q;
    logic frameEnd;
    logic mfEnd;
    assign frameEnd = (octetIdx_q == frameLast(modeSel_q));
    assign mfEnd = frameEnd && (frameIdx_q == kMinus1_q);

    // held at zero while disabled; reference capture realigns in subclass 1
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            octetIdx_q <= 2'h0;
            frameIdx_q <= 5'h00;
            mfOctet_q <= 7'h00;
        end
        else if (clockEnable)
        begin
            if (!linkOn || (ctrl_q[jltx_pkg::CTRL_SUBCLASS1_BIT] && sysrefEdge))
            begin
                octetIdx_q <= 2'h0;
                frameIdx_q <= 5'h00;
                mfOctet_q <= 7'h00;
            end
            else
            begin
                octetIdx_q <= frameEnd ? 2'h0 : octetIdx_q + 2'h1;
                mfOctet_q <= mfEnd ? 7'h00 : mfOctet_q + 7'h01;
                if (frameEnd)
                    frameIdx_q <= mfEnd ? 5'h00 : frameIdx_q + 5'h01;
            end
        end
    end

    // ****************************************************************
    // transport packing
    // ****************************************************************
    logic [31:0] frameWord_q;
    logic [31:0] nextWord;
    logic [1:0] byteSel;

    // sample source and placement per mode
    always_comb
    begin
        unique case (modeSel_q)
            jltx_pkg::MODE_DDC_F2: nextWord = {ddcSample.i, 16'h0000};
            jltx_pkg::MODE_DDC_F4: nextWord = ddcSample;
            default: nextWord = {adcSample, 16'h0000};
        endcase
    end

    // new sample word latched at each frame end, sent during the next frame
    assign sampleTaken = linkOn && frameEnd;
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            frameWord_q <= 32'h0000_0000;
        else if (clockEnable)
        begin
            if (!linkOn)
                frameWord_q <= 32'h0000_0000;
            else if (frameEnd)
                frameWord_q <= nextWord;
        end
    end

    assign byteSel = 2'h3 - octetIdx_q;

    // ****************************************************************
    // link state machine
    // ****************************************************************
    logic [3:0] syncLowCnt_q;
    logic resync;
    assign resync = !syncLevel_q && (syncLowCnt_q == jltx_pkg::SYNC_REASSERT_CYCLES - 4'h1);

    // counts cycles of active request while aligning or sending data
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            syncLowCnt_q <= 4'h0;
        else if (clockEnable)
        begin
            if (syncLevel_q || (state_q != jltx_pkg::ST_ILAS && state_q != jltx_pkg::ST_DATA))
                syncLowCnt_q <= 4'h0;
            else if (!resync)
                syncLowCnt_q <= syncLowCnt_q + 4'h1;
        end
    end

    // bring-up sequence; a short glitch on the request is ignored during alignment and data
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state_q <= jltx_pkg::ST_OFF;
            ilasMf_q <= 2'h0;
        end
        else if (clockEnable)
        begin
            if (!linkOn)
                state_q <= jltx_pkg::ST_OFF;
            else
            begin
                unique case (state_q)
                    jltx_pkg::ST_OFF: state_q <= jltx_pkg::ST_CGS;
                    jltx_pkg::ST_CGS:
                        if (syncLevel_q)
                            state_q <= jltx_pkg::ST_WAIT;
                    jltx_pkg::ST_WAIT:
                        if (!syncLevel_q)
                            state_q <= jltx_pkg::ST_CGS;
                        else if (mfEnd)
                            state_q <= jltx_pkg::ST_ILAS;
                    jltx_pkg::ST_ILAS:
                        if (resync)
                            state_q <= jltx_pkg::ST_CGS;
                        else if (mfEnd && ilasMf_q == jltx_pkg::ILAS_LAST_MF)
                            state_q <= jltx_pkg::ST_DATA;
                    jltx_pkg::ST_DATA:
                        if (resync)
                            state_q <= jltx_pkg::ST_CGS;
                endcase
            end
            if (state_q != jltx_pkg::ST_ILAS)
                ilasMf_q <= 2'h0;
            else if (mfEnd)
                ilasMf_q <= ilasMf_q + 2'h1;
        end
    end

    // ****************************************************************
    // octet selection, scrambling and alignment characters
    // ****************************************************************
    logic [14:0] scrState_q;
    logic [7:0] prevLast_q;
    logic rd_q;
    logic [7:0] rawOctet;
    logic [22:0] scrResult;
    jltx_pkg::jltx_octet_type ilasOctet;
    jltx_pkg::jltx_octet_type dataOctet;
    jltx_pkg::jltx_octet_type txOctet;
    logic [10:0] encoded;

    assign rawOctet = frameWord_q[{byteSel, 3'b000} +: 8];
    assign scrResult = scramble(rawOctet, scrState_q);

    // alignment multiframes: start, config marker, parameters, then a ramp
    always_comb
    begin
        ilasOctet = '{isK: 1'b0, value: {1'b0, mfOctet_q}};
        if (mfEnd)
            ilasOctet = '{isK: 1'b1, value: jltx_pkg::K28_3};
        else if (mfOctet_q == 7'h00)
            ilasOctet = '{isK: 1'b1, value: jltx_pkg::K28_0};
        else if (ilasMf_q == 2'h1)
        begin
            unique case (mfOctet_q)
                7'h01: ilasOctet = '{isK: 1'b1, value: jltx_pkg::K28_4};
                7'h02: ilasOctet = '{isK: 1'b0, value: {4'h0, modeSel_q}};
                7'h03: ilasOctet = '{isK: 1'b0, value: {3'h0, kMinus1_q}};
                7'h04: ilasOctet = '{isK: 1'b0, value: {3'h0, ctrl_q, frameLast(modeSel_q)}};
                default: ;
            endcase
        end
    end

    // data path: optional scrambling, then frame and multiframe marking
    always_comb
    begin
        dataOctet = '{isK: 1'b0, value: scrOn ? scrResult[7:0] : rawOctet};
        if (frameEnd && (scrOn ? scrResult[7:0] == jltx_pkg::SCR_MARK_OCTET
                               : rawOctet == prevLast_q))
            dataOctet = '{isK: 1'b1, value: mfEnd ? jltx_pkg::K28_3 : jltx_pkg::K28_7};
    end

    // what goes on the lane in each state
    always_comb
    begin
        unique case (state_q)
            jltx_pkg::ST_ILAS: txOctet = ilasOctet;
            jltx_pkg::ST_DATA: txOctet = dataOctet;
            default: txOctet = '{isK: 1'b1, value: jltx_pkg::K28_5};
        endcase
    end

    assign encoded = encode(txOctet, rd_q);

    // scrambler only advances on data, so the alignment octets stay clear
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            scrState_q <= 15'h0000;
            prevLast_q <= 8'h00;
        end
        else if (clockEnable)
        begin
            if (state_q != jltx_pkg::ST_DATA)
            begin
                scrState_q <= 15'h0000;
                prevLast_q <= 8'h00;
            end
            else
            begin
                if (scrOn)
                    scrState_q <= scrResult[22:8];
                if (frameEnd)
                    prevLast_q <= rawOctet;
            end
        end
    end

    // ****************************************************************
    // encoded output stage
    // ****************************************************************
    logic [9:0] lineChar_q;
    logic lineValid_q;

    // running disparity restarts negative whenever the link is off
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            lineChar_q <= 10'h000;
            lineValid_q <= 1'b0;
            rd_q <= 1'b0;
        end
        else if (clockEnable)
        begin
            if (state_q == jltx_pkg::ST_OFF)
            begin
                lineChar_q <= 10'h000;
                lineValid_q <= 1'b0;
                rd_q <= 1'b0;
            end
            else
            begin
                lineChar_q <= encoded[9:0];
                lineValid_q <= 1'b1;
                rd_q <= encoded[10];
            end
        end
    end

    assign lineChar = lineChar_q;
    assign lineValid = lineValid_q;
endmodule // jltx_top

// [verification/jltx_chk.sv]
// port-level assertion checker for the serial link transmitter
module jltx_chk
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWriteData,
    input wire logic regWrite,
    input wire logic sampleTaken,
    input wire logic syncPinN,
    input wire logic [9:0] lineChar,
    input wire logic lineValid,
    input wire logic serPowerDown,
    input wire logic [3:0] serPreEmphasis
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // helpers and properties
    // ****************
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic [4:0] lowCnt_q;
    wire logic comma = (lineChar == 10'h0FA) || (lineChar == 10'h305);
    // saturating run of sync-low cycles; a long run must force commas
    always_ff @(posedge clock or posedge reset)
        if (reset) lowCnt_q <= 5'h00;
        else lowCnt_q <= syncPinN ? 5'h00 : lowCnt_q + {4'h0, lowCnt_q != 5'h1F};
    pd_off_a: assert property (serPowerDown |=> ##1 !lineValid)
        else $error("line active while off");
    cgs_start_a: assert property ($fell(serPowerDown)
        |=> ##1 (lineValid && lineChar == 10'h0FA)) else $error("no comma after enable");
    comma_hold_a: assert property (lowCnt_q >= 5'h14 && lineValid |-> comma)
        else $error("no comma under long sync");
    sync_wait_a: assert property ($rose(syncPinN) && comma |=> comma [*6])
        else $error("alignment started too early");
    pe_hold_a: assert property (!$past(regWrite) |-> $stable(serPreEmphasis))
        else $error("preemphasis moved");
    pe_load_a: assert property ($past(regWrite) && $past(regAddr) == jltx_pkg::ADDR_PREEMPH
        |-> serPreEmphasis == $past(regWriteData[3:0])) else $error("preemphasis not loaded");
    pd_load_a: assert property ($past(regWrite) && $past(regAddr) == jltx_pkg::ADDR_CTRL
        |-> serPowerDown == !$past(regWriteData[0])) else $error("enable not applied");
    take_on_a: assert property (sampleTaken |-> !serPowerDown)
        else $error("sample taken while off");
    dc_bal_a: assert property (lineValid |-> $countones(lineChar) inside {4, 5, 6})
        else $error("unbalanced character");
    cover property ($fell(serPowerDown));
    cover property ($rose(syncPinN) && comma);
    cover property (lowCnt_q == 5'h1F && lineValid);
endmodule // jltx_chk

bind jltx_top jltx_chk u_chk (.clock(clock), .reset(reset), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .sampleTaken(sampleTaken),
    .syncPinN(syncPinN), .lineChar(lineChar), .lineValid(lineValid),
    .serPowerDown(serPowerDown), .serPreEmphasis(serPreEmphasis));

// [verification/jltx_rx_model.sv]
// receiving-side model: locks on commas and drives the sync request
module jltx_rx_model
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [9:0] lineChar,
    input wire logic lineValid,
    input wire logic holdLow,
    output logic syncN
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] commas_q;
    logic [2:0] lmfc_q;
    logic locked_q;
    // comma run, own multiframe counter, lock; a dead line drops the lock
    always_ff @(posedge clock or posedge reset)
        if (reset)
        begin
            commas_q <= 3'h0;
            lmfc_q <= 3'h0;
            locked_q <= 1'b0;
        end
        else
        begin
            lmfc_q <= lmfc_q + 3'h1;
            if (!lineValid || (lineChar != 10'h0FA && lineChar != 10'h305)) commas_q <= 3'h0;
            else if (commas_q != 3'h4) commas_q <= commas_q + 3'h1;
            if (!lineValid) locked_q <= 1'b0;
            else if (commas_q == 3'h4 && lmfc_q == 3'h0) locked_q <= 1'b1;
        end
    // low means request commas
    assign syncN = locked_q && !holdLow;
endmodule // jltx_rx_model

// [verification/testbench.sv]
// self-checking bench for the serial link transmitter
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0, holdLow = 1'b0;
    logic sysrefPin = 1'b0, sysOn = 1'b0, sampleTaken, syncN, lineValid, serPowerDown;
    logic [3:0] regAddr = 4'h0, serPreEmphasis;
    logic [31:0] regWriteData = 32'h0000_0000, regReadData, d;
    logic [15:0] adcSample = 16'hA55A;
    logic [9:0] lineChar;
    int mismatches = 0, num_checks = 0, cyc = 0;
    // ****************
    // clocks, parts, shared tasks
    // ****************
    always #2.5 clock = ~clock;
    // sysref only pulses when asked; the counters run freely otherwise
    always #24 if (sysOn) sysrefPin <= ~sysrefPin;
    jltx_top u_dut (.clock(clock), .reset(reset), .clockEnable(1'b1), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .adcSample(adcSample), .ddcSample(32'h1234_5678),
        .sampleTaken(sampleTaken), .syncPinN(syncN), .sysrefPin(sysrefPin),
        .lineChar(lineChar), .lineValid(lineValid), .serPowerDown(serPowerDown),
        .serPreEmphasis(serPreEmphasis));
    jltx_rx_model u_rx (.clock(clock), .reset(reset), .lineChar(lineChar),
        .lineValid(lineValid), .holdLow(holdLow), .syncN(syncN));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // hang guard well above the few hundred cycles the run needs
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            mismatches++;
            tally_and_finish;
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic isk(input logic [9:0] c, input logic [9:0] v);
        return c === v || c === ~v;
    endfunction
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        regAddr <= a;
        regWriteData <= v;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
        @(posedge clock);
    endtask
    // data is only valid in the cycle after the strobe, so sample there
    task automatic rd(input logic [3:0] a);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1 d = regReadData;
        @(posedge clock);
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_regs;
        chk("pd", 1, serPowerDown);
        rd(jltx_pkg::ADDR_CTRL);
        chk("ctrl", 0, d);
        rd(jltx_pkg::ADDR_MODE);
        chk("mode", 32'h0000_0F00, d);
        wr(4'h2, 32'hFFFF_FFFF);
        rd(4'h2);
        chk("unmapped", 0, d);
    endtask
    task automatic t_pe;
        wr(jltx_pkg::ADDR_PREEMPH, 32'h0000_000F);
        wr(jltx_pkg::ADDR_PREEMPH, 32'h0000_0005);
        rd(jltx_pkg::ADDR_PREEMPH);
        chk("pe reg", 5, d);
        chk("pe pin", 5, serPreEmphasis);
    endtask
    // one K28.0 per alignment multiframe, config marker once, then markers per frame when unscrambled
    task automatic bring_up(input logic [31:0] ctrl, input logic scramble_enable);
        int first = -1, last = 0, k0 = 0, k4 = 0, mk = 0, ka = 0;
        sysOn <= scramble_enable;
        wr(jltx_pkg::ADDR_CTRL, ctrl);
        for (int t = 0; t < 160; t++)
        begin
            @(posedge clock);
            #1;
            if (t == 3) sysOn <= 1'b0; // stop well before alignment
            if (isk(lineChar, 10'h0F4))
            begin
                if (first < 0) first = t;
                last = t;
                k0++;
            end
            if (isk(lineChar, 10'h0F2)) k4++;
            if (first >= 0 && t >= last + 16 && t < last + 48)
            begin
                if (isk(lineChar, 10'h0F8)) mk++;
                if (isk(lineChar, 10'h0F3)) ka++;
            end
        end
        chk("ilas mf", 4, k0);
        chk("ilas cfg", 1, k4);
        chk("ilas span", 24, last - first);
        if (!scramble_enable) chk("frame mark", 12, mk);
        if (!scramble_enable) chk("mf mark", 4, ka);
        if (scramble_enable) chk("scr marks", 1, mk + ka < 16);
    endtask
    task automatic t_resync;
        int n = 0;
        holdLow <= 1'b1;
        repeat (4) @(posedge clock);
        holdLow <= 1'b0;
        repeat (20) @(posedge clock) #1 n += isk(lineChar, 10'h0FA);
        chk("short low", 0, n);
        holdLow <= 1'b1;
        repeat (24) @(posedge clock) #1 n += isk(lineChar, 10'h0FA);
        holdLow <= 1'b0;
        chk("long low", 1, n > 0);
        repeat (100) @(posedge clock);
        rd(jltx_pkg::ADDR_STATUS);
        chk("back to data", 4, d[2:0]);
    endtask
    task automatic t_off;
        wr(jltx_pkg::ADDR_CTRL, 32'h0000_0000);
        repeat (2) @(posedge clock);
        chk("off valid", 0, lineValid);
        chk("off pd", 1, serPowerDown);
    endtask
    initial
    begin
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        t_regs;
        t_pe;
        wr(jltx_pkg::ADDR_MODE, 32'h0000_0301);
        bring_up(32'h0000_0001, 1'b0);
        t_resync;
        t_off;
        bring_up(32'h0000_0007, 1'b1);
        t_off;
        tally_and_finish;
    end
endmodule // testbench
